// File: rtl/agccs_pkg.sv
package agccs_pkg;

    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_CTRL_HIGH   = 8'h1b;
    localparam logic [7:0] IDX_CTRL_MID    = 8'h1c;
    localparam logic [7:0] IDX_CTRL_LOW    = 8'h1d;
    localparam logic [7:0] IDX_STATUS      = 8'h30;
    localparam logic [7:0] IDX_MANUAL_GAIN = 8'h31;

    // reset values
    localparam logic [7:0] RST_CTRL_HIGH   = 8'h03;
    localparam logic [7:0] RST_CTRL_MID    = 8'h40;
    localparam logic [7:0] RST_CTRL_LOW    = 8'h91;
    localparam logic [7:0] RST_MANUAL_GAIN = 8'h00;

    // gain hold modes
    localparam logic [1:0] HOLD_NONE   = 2'h0;
    localparam logic [1:0] HOLD_SYNC   = 2'h1;
    localparam logic [1:0] HOLD_ANALOG = 2'h2;
    localparam logic [1:0] HOLD_ALL    = 2'h3;

    // code that switches the absolute criterion off
    localparam logic [3:0] CS_ABS_OFF = 4'h8;

    // counts
    localparam logic [6:0] WAIT_UNIT   = 7'h08;  // samples per wait step
    localparam logic [3:0] OOK_UNIT_DB = 4'h4;   // dB per span step
    localparam logic [2:0] GAIN_MAX    = 3'h7;
    localparam logic [9:0] ANA_STEP_DB = 10'h006;
    localparam logic [9:0] DIG_STEP_DB = 10'h003;

    typedef struct packed {
        logic [1:0] hyst;
        logic [1:0] wait_sel;
        logic [1:0] hold;
        logic [1:0] span;
    } agccs_ctrl_low_t;

    typedef struct packed {
        logic       rsvd;
        logic       lna_priority;
        logic [1:0] rel_level;
        logic [3:0] abs_level;
    } agccs_ctrl_mid_t;

    typedef struct packed {
        logic [2:0] analog;
        logic [2:0] digital;
    } agccs_gain_t;

endpackage

// File: rtl/agccs_core.sv
// Register access over Avalon-MM was decided locally.
`timescale 1ns/10ps
`default_nettype none
module agccs_core #(
    parameter int AMP_W = 8
) (
    input  wire logic             clk_sys,
    input  wire logic             resetn,
    input  wire logic [7:0]       avs_address,
    input  wire logic             avs_read,
    input  wire logic             avs_write,
    input  wire logic [31:0]      avs_writedata,
    input  wire logic [3:0]       avs_byteenable,
    output logic      [31:0]      avs_readdata,
    output logic                  avs_waitrequest,
    input  wire logic             sample_valid,
    input  wire logic [AMP_W-1:0] sample_amp,
    input  wire logic             sync_found,
    input  wire logic             rx_restart,
    output logic      [2:0]       analog_gain,
    output logic      [2:0]       digital_gain,
    output logic                  carrier_sense,
    output logic                  ook_bit
);

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    agccs_pkg::agccs_ctrl_low_t ctrl_low_ff;
    agccs_pkg::agccs_ctrl_mid_t ctrl_mid_ff;
    logic [7:0]                 ctrl_high_ff;
    logic [7:0]                 manual_ff;
    logic                       waitreq_ff;
    logic [31:0]                rdata_ff;
    agccs_pkg::agccs_gain_t     gain_ff;
    logic                       cs_ff;
    logic                       ook_ff;
    logic                       frozen_ff;
    logic [AMP_W-1:0]           avg_ff;
    logic                       avg_valid_ff;

    wire       req       = avs_read | avs_write;
    wire [7:0] idx       = {2'h0, avs_address[7:2]};
    wire       hit_high  = idx == agccs_pkg::IDX_CTRL_HIGH;
    wire       hit_mid   = idx == agccs_pkg::IDX_CTRL_MID;
    wire       hit_low   = idx == agccs_pkg::IDX_CTRL_LOW;
    wire       hit_stat  = idx == agccs_pkg::IDX_STATUS;
    wire       hit_man   = idx == agccs_pkg::IDX_MANUAL_GAIN;
    wire       wr_take   = avs_write & ~waitreq_ff & avs_byteenable[0];
    wire [7:0] wbyte     = avs_writedata[7:0];
    wire [15:0] status_w = {avg_ff, cs_ff, frozen_ff, gain_ff};

    // read mux; unmapped words read as zero
    wire [31:0] nxt_rdata =
        hit_high ? {24'h0, ctrl_high_ff} :
        hit_mid  ? {24'h0, 1'b0, ctrl_mid_ff[6:0]} :
        hit_low  ? {24'h0, ctrl_low_ff} :
        hit_stat ? {16'h0, status_w} :
        hit_man  ? {24'h0, manual_ff} : 32'h0;

    // one wait cycle, then the answer stands for one cycle
    wire nxt_waitreq = ~(req & waitreq_ff);

    // bus handshake and read data
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            waitreq_ff <= 1'b1;
            rdata_ff   <= 32'h0;
        end
        else
        begin
            waitreq_ff <= nxt_waitreq;
            rdata_ff   <= (req & waitreq_ff) ? nxt_rdata : rdata_ff;
        end
    end

    // writable registers, taken at the edge waitrequest is seen low
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            ctrl_high_ff <= agccs_pkg::RST_CTRL_HIGH;
            ctrl_mid_ff  <= agccs_pkg::RST_CTRL_MID;
            ctrl_low_ff  <= agccs_pkg::RST_CTRL_LOW;
            manual_ff    <= agccs_pkg::RST_MANUAL_GAIN;
        end
        else
        begin
            if (wr_take & hit_high) ctrl_high_ff <= wbyte;
            if (wr_take & hit_mid)  ctrl_mid_ff  <= {1'b0, wbyte[6:0]};
            if (wr_take & hit_low)  ctrl_low_ff  <= wbyte;
            if (wr_take & hit_man)  manual_ff    <= wbyte;
        end
    end

    // ------------------------------------------------------------
    // field decode
    // ------------------------------------------------------------
    logic [9:0] goal_db;
    always_comb
    begin
        unique case (ctrl_high_ff[2:0])
            3'h0: goal_db = 10'd24;
            3'h1: goal_db = 10'd27;
            3'h2: goal_db = 10'd30;
            3'h3: goal_db = 10'd33;
            3'h4: goal_db = 10'd36;
            3'h5: goal_db = 10'd38;
            3'h6: goal_db = 10'd40;
            3'h7: goal_db = 10'd42;
        endcase
    end

    logic [9:0] dz_hi;
    logic [9:0] dz_lo;
    // dead zone above and below the goal per hysteresis level
    always_comb
    begin
        unique case (ctrl_low_ff.hyst)
            2'h0: begin dz_hi = 10'd2; dz_lo = 10'd2; end
            2'h1: begin dz_hi = 10'd2; dz_lo = 10'd4; end
            2'h2: begin dz_hi = 10'd3; dz_lo = 10'd6; end
            2'h3: begin dz_hi = 10'd5; dz_lo = 10'd10; end
        endcase
    end

    // span of 8 << sel samples
    wire [6:0] span_n   = 7'h08 << ctrl_low_ff.span;
    wire [2:0] span_shf = 3'h3 + {1'b0, ctrl_low_ff.span};
    // discard count of 8 * (sel + 1)
    wire [6:0] wait_n   = agccs_pkg::WAIT_UNIT *
                          (7'h01 + {5'h0, ctrl_low_ff.wait_sel});
    // boundary of 4 * (span + 1) dB; 16 dB needs a fifth bit
    wire [4:0] ook_db   = {1'b0, agccs_pkg::OOK_UNIT_DB} *
                          (5'h01 + {3'h0, ctrl_low_ff.span});
    wire [1:0] hold     = ctrl_low_ff.hold;

    // ------------------------------------------------------------
    // averaging and post-adjust discard
    // ------------------------------------------------------------
    logic [6:0]  cnt_ff;
    logic [6:0]  wait_ff;
    logic [13:0] acc_ff;

    wire        take_smp  = sample_valid & (wait_ff == 7'h0);
    wire [13:0] acc_sum   = acc_ff + {{(14-AMP_W){1'b0}}, sample_amp};
    wire        span_done = take_smp & (cnt_ff == span_n - 7'h01);
    wire [13:0] avg_full  = acc_sum >> span_shf;
    wire        adjust;

    // accumulate, discard after an adjustment, publish averages
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            cnt_ff       <= 7'h0;
            acc_ff       <= 14'h0;
            wait_ff      <= 7'h0;
            avg_ff       <= '0;
            avg_valid_ff <= 1'b0;
        end
        else
        begin
            avg_valid_ff <= span_done & ~(wr_take & hit_low);
            // a new span setting restarts the running sum
            if (wr_take & hit_low)
            begin
                cnt_ff <= 7'h0;
                acc_ff <= 14'h0;
            end
            else if (span_done)
            begin
                cnt_ff <= 7'h0;
                acc_ff <= 14'h0;
                avg_ff <= avg_full[AMP_W-1:0];
            end
            else if (take_smp)
            begin
                cnt_ff <= cnt_ff + 7'h01;
                acc_ff <= acc_sum;
            end
            // discard window starts after each loop gain step, not after an override load
            if (adjust)
                wait_ff <= wait_n;
            else if (sample_valid & (wait_ff != 7'h0))
                wait_ff <= wait_ff - 7'h01;
        end
    end

    // ------------------------------------------------------------
    // gain loop
    // ------------------------------------------------------------
    wire [9:0] avg_w    = {{(10-AMP_W){1'b0}}, avg_ff};
    wire [9:0] red_db   = {7'h0, gain_ff.analog} * agccs_pkg::ANA_STEP_DB +
                          {7'h0, gain_ff.digital} * agccs_pkg::DIG_STEP_DB;
    wire       too_hot  = avg_w > goal_db + dz_hi;
    wire       too_cold = avg_w + dz_lo < goal_db;
    wire       ana_free = (hold == agccs_pkg::HOLD_NONE) |
                          ((hold == agccs_pkg::HOLD_SYNC) & ~frozen_ff);
    wire       dig_free = ana_free | (hold == agccs_pkg::HOLD_ANALOG);
    wire       ana_dn   = ana_free & too_hot & (gain_ff.analog != 3'h7);
    wire       dig_dn   = dig_free & too_hot & ~ana_dn &
                          (gain_ff.digital != agccs_pkg::GAIN_MAX);
    wire       dig_up   = dig_free & too_cold & (gain_ff.digital != 3'h0);
    wire       ana_up   = ana_free & too_cold & ~dig_up &
                          (gain_ff.analog != 3'h0);
    assign adjust = avg_valid_ff & (ana_dn | dig_dn | dig_up | ana_up);

    agccs_pkg::agccs_gain_t nxt_gain;
    // free adjustment; analog reduced first, digital restored first
    // analog held in hold mode two
    // both gains taken from the override register
    always_comb
    begin
        nxt_gain = gain_ff;
        if (hold == agccs_pkg::HOLD_ALL)
            nxt_gain = manual_ff[5:0];
        else if (avg_valid_ff)
        begin
            if (ana_dn) nxt_gain.analog  = gain_ff.analog + 3'h1;
            if (dig_dn) nxt_gain.digital = gain_ff.digital + 3'h1;
            if (dig_up) nxt_gain.digital = gain_ff.digital - 3'h1;
            if (ana_up) nxt_gain.analog  = gain_ff.analog - 3'h1;
        end
    end

    // freeze on sync word, released by a new reception
    wire nxt_frozen = (hold == agccs_pkg::HOLD_SYNC) &
                      (sync_found | (frozen_ff & ~rx_restart));

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            gain_ff   <= '0;
            frozen_ff <= 1'b0;
        end
        else
        begin
            gain_ff   <= nxt_gain;
            frozen_ff <= nxt_frozen;
        end
    end

    // ------------------------------------------------------------
    // carrier sense and on-off keying slicer
    // ------------------------------------------------------------
    logic [9:0] rssi_prev_ff;
    logic [9:0] rel_db;
    // relative step per setting, zero code disables
    always_comb
    begin
        unique case (ctrl_mid_ff.rel_level)
            2'h0: rel_db = 10'd0;
            2'h1: rel_db = 10'd6;
            2'h2: rel_db = 10'd10;
            2'h3: rel_db = 10'd14;
        endcase
    end

    wire [3:0] abs_lvl = ctrl_mid_ff.abs_level;
    // strength is amplitude plus the gain already taken away
    wire [9:0] rssi_db = avg_w + red_db;
    wire [9:0] abs_thr = goal_db + {{6{abs_lvl[3]}}, abs_lvl};
    // most negative code disables the absolute test
    wire       abs_on  = abs_lvl != agccs_pkg::CS_ABS_OFF;
    wire       abs_hit = abs_on & (rssi_db >= abs_thr);
    wire       rel_hit = (rel_db != 10'd0) & (rssi_db >= rssi_prev_ff + rel_db);
    // either criterion alone asserts carrier sense
    wire       nxt_cs  = abs_hit | rel_hit;
    // sample above average minus boundary slices as one
    wire [9:0] smp_w   = {{(10-AMP_W){1'b0}}, sample_amp};
    wire       nxt_ook = smp_w + {5'h0, ook_db} > avg_w;

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            cs_ff        <= 1'b0;
            rssi_prev_ff <= 10'h0;
            ook_ff       <= 1'b0;
        end
        else
        begin
            if (avg_valid_ff)
            begin
                cs_ff        <= nxt_cs;
                rssi_prev_ff <= rssi_db;
            end
            if (sample_valid)
                ook_ff <= nxt_ook;
        end
    end

    assign avs_readdata    = rdata_ff;
    assign avs_waitrequest = waitreq_ff;
    assign analog_gain     = gain_ff.analog;
    assign digital_gain    = gain_ff.digital;
    assign carrier_sense   = cs_ff;
    assign ook_bit         = ook_ff;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    a_abs_off_quiet: assert property (
        avg_valid_ff & ~abs_on & (rel_db == 10'd0) |=> !carrier_sense)
        else $error("carrier sense with both criteria off");

    a_abs_hit_sense: assert property (
        avg_valid_ff & abs_on & (rssi_db >= abs_thr) |=> carrier_sense)
        else $error("absolute threshold crossing missed");

    a_rel_alone: assert property (
        avg_valid_ff & ~abs_on & rel_hit |=> carrier_sense)
        else $error("relative criterion ignored");

    a_wait_window: assert property (
        adjust |=> wait_ff == $past(wait_n))
        else $error("discard window wrong length");

    a_wait_discard: assert property (
        sample_valid & (wait_ff != 7'h0) & ~span_done |=> $stable(cnt_ff))
        else $error("sample used during discard");

    a_span_bound: assert property (
        cnt_ff < span_n)
        else $error("average span overrun");

    a_hold_analog: assert property (
        hold == agccs_pkg::HOLD_ANALOG ##1 hold == agccs_pkg::HOLD_ANALOG
        |-> $stable(analog_gain))
        else $error("analog gain moved while held");

    a_hold_manual: assert property (
        hold == agccs_pkg::HOLD_ALL |=> {analog_gain, digital_gain} ==
        $past(manual_ff[5:0]))
        else $error("override gain not applied");

    a_hold_sync: assert property (
        frozen_ff & (hold == agccs_pkg::HOLD_SYNC) |=>
        $stable({analog_gain, digital_gain}))
        else $error("gain moved after sync");

    a_free_reduce: assert property (
        avg_valid_ff & (hold == agccs_pkg::HOLD_NONE) & too_hot &
        (gain_ff.analog != 3'h7) |=> analog_gain == $past(analog_gain) + 3'h1)
        else $error("gain not reduced when strong");

    a_bus_answer: assert property (
        req & avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("bus answer not one cycle after wait");

    c_adjust:  cover property (adjust);
    c_freeze:  cover property (frozen_ff ##1 rx_restart);
    c_sense:   cover property (avg_valid_ff ##1 carrier_sense);
    c_rd_stat: cover property (avs_read & hit_stat & !avs_waitrequest);

endmodule
`default_nettype wire

// File: dv/tb_agc_carrier_sense_control.sv
`timescale 1ns/10ps
`default_nettype none
module tb_agc_carrier_sense_control;

    // ------------------------------------------------------------
    // signals and tables
    // ------------------------------------------------------------
    logic        clk_sys;
    logic        resetn;
    logic [7:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        sample_valid;
    logic [7:0]  sample_amp;
    logic        sync_found;
    logic        rx_restart;
    logic [2:0]  analog_gain;
    logic [2:0]  digital_gain;
    logic        carrier_sense;
    logic        ook_bit;
    int          fail_count;
    int          tests_run;
    logic [3:0]  abs_tab [6] = '{4'h0, 4'h1, 4'h2, 4'hf, 4'hb, 4'h8};
    logic [7:0]  amp_tab [6] = '{8'h21, 8'h21, 8'h22, 8'h20, 8'h1c, 8'h23};
    logic        cs_tab  [6] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
    logic [7:0]  bnd;

    agccs_core DUT (
        .clk_sys         (clk_sys),
        .resetn          (resetn),
        .avs_address     (avs_address),
        .avs_read        (avs_read),
        .avs_write       (avs_write),
        .avs_writedata   (avs_writedata),
        .avs_byteenable  (avs_byteenable),
        .avs_readdata    (avs_readdata),
        .avs_waitrequest (avs_waitrequest),
        .sample_valid    (sample_valid),
        .sample_amp      (sample_amp),
        .sync_found      (sync_found),
        .rx_restart      (rx_restart),
        .analog_gain     (analog_gain),
        .digital_gain    (digital_gain),
        .carrier_sense   (carrier_sense),
        .ook_bit         (ook_bit)
    );

    // free running 100 MHz clock
    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // ------------------------------------------------------------
    // compare and report
    // ------------------------------------------------------------
    task automatic tally_and_finish();
        if (fail_count == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk_reg(input string nm, input logic [31:0] e,
                           input logic [31:0] g);
        tests_run++;
        if (g !== e)
        begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_gain(input string nm, input logic [2:0] e,
                            input logic [2:0] g);
        tests_run++;
        if (g !== e)
        begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_bit(input string nm, input logic e, input logic g);
        tests_run++;
        if (g !== e)
        begin
            fail_count++;
            $display("mismatch %s expected %b seen %b", nm, e, g);
        end
    endtask

    // ------------------------------------------------------------
    // avalon master: hold request until waitrequest seen low
    // ------------------------------------------------------------
    task automatic bus_wait(output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge clk_sys);
        while (avs_waitrequest !== 1'b0)
        begin
            n++;
            if (n > 64)
            begin
                fail_count++;
                tally_and_finish();
            end
            @(posedge clk_sys);
        end
        rd = avs_readdata;
    endtask

    task automatic bus_wr(input logic [7:0] a, input logic [7:0] d,
                          input logic [3:0] be);
        logic [31:0] unused_rd;
        @(posedge clk_sys);
        avs_address    <= a;
        avs_writedata  <= {24'h000000, d};
        avs_byteenable <= be;
        avs_write      <= 1'b1;
        bus_wait(unused_rd);
        avs_write <= 1'b0;
    endtask

    task automatic bus_rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] got;
        @(posedge clk_sys);
        avs_address <= a;
        avs_read    <= 1'b1;
        bus_wait(got);
        avs_read <= 1'b0;
        chk_reg("readdata", e, got);
    endtask

    // ------------------------------------------------------------
    // sample stream: n samples, then let average land at outputs
    // ------------------------------------------------------------
    task automatic feed(input int n, input logic [7:0] amp);
        repeat (n)
        begin
            @(posedge clk_sys);
            sample_valid <= 1'b1;
            sample_amp   <= amp;
        end
        @(posedge clk_sys);
        sample_valid <= 1'b0;
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask

    task automatic ook_probe(input logic [7:0] amp, input logic e);
        @(posedge clk_sys);
        sample_valid <= 1'b1;
        sample_amp   <= amp;
        @(posedge clk_sys);
        sample_valid <= 1'b0;
        @(negedge clk_sys);
        chk_bit("ook_bit", e, ook_bit);
    endtask

    task automatic pulse_sync();
        @(posedge clk_sys);
        sync_found <= 1'b1;
        @(posedge clk_sys);
        sync_found <= 1'b0;
    endtask

    task automatic pulse_restart();
        @(posedge clk_sys);
        rx_restart <= 1'b1;
        @(posedge clk_sys);
        rx_restart <= 1'b0;
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        fail_count     = 0;
        tests_run      = 0;
        resetn         = 1'b0;
        avs_address    = 8'h00;
        avs_read       = 1'b0;
        avs_write      = 1'b0;
        avs_writedata  = 32'h00000000;
        avs_byteenable = 4'h0;
        sample_valid   = 1'b0;
        sample_amp     = 8'h00;
        sync_found     = 1'b0;
        rx_restart     = 1'b0;
        repeat (6) @(posedge clk_sys);
        resetn <= 1'b1;
        // reset values, unmapped place, disabled byte lane
        bus_rd(8'h6c, 32'h00000003);
        bus_rd(8'h70, 32'h00000040);
        bus_rd(8'h74, 32'h00000091);
        bus_rd(8'hc4, 32'h00000000);
        bus_wr(8'hf0, 8'h5a, 4'hf);
        bus_rd(8'hf0, 32'h00000000);
        bus_wr(8'h74, 8'h00, 4'he);
        bus_rd(8'h74, 32'h00000091);
        // signed absolute level against amplitude goal
        for (int i = 0; i < 6; i++)
        begin
            bus_wr(8'h70, {4'hc, abs_tab[i]}, 4'hf);
            bus_rd(8'h70, {24'h000000, 4'h4, abs_tab[i]});
            feed(16, amp_tab[i]);
            chk_bit("carrier_sense", cs_tab[i], carrier_sense);
        end
        bus_rd(8'hc0, 32'h00002300);
        bus_wr(8'h70, 8'h40, 4'hf);
        // free adjustment and discard window after a change
        feed(16, 8'h2d);
        chk_gain("analog_gain", 3'h1, analog_gain);
        feed(16, 8'h0a);
        feed(16, 8'h27);
        chk_gain("analog_gain", 3'h2, analog_gain);
        chk_gain("digital_gain", 3'h0, digital_gain);
        // analog fixed, digital keeps moving
        bus_wr(8'h74, 8'h99, 4'hf);
        feed(16, 8'h21);
        feed(16, 8'h2d);
        chk_gain("analog_gain", 3'h2, analog_gain);
        chk_gain("digital_gain", 3'h1, digital_gain);
        // manual override of both gains
        bus_wr(8'hc4, 8'h0b, 4'hf);
        bus_rd(8'hc4, 32'h0000000b);
        bus_wr(8'h74, 8'h9d, 4'hf);
        feed(16, 8'h21);
        feed(16, 8'h2d);
        chk_gain("analog_gain", 3'h1, analog_gain);
        chk_gain("digital_gain", 3'h3, digital_gain);
        // freeze on sync word, release on new reception
        bus_wr(8'h74, 8'h95, 4'hf);
        pulse_sync();
        feed(32, 8'h2d);
        chk_gain("analog_gain", 3'h1, analog_gain);
        chk_gain("digital_gain", 3'h3, digital_gain);
        pulse_restart();
        feed(16, 8'h2d);
        chk_gain("analog_gain", 3'h2, analog_gain);
        // let the discard window after that step run out
        feed(16, 8'h21);
        // averaging span and matching on-off keying boundary
        for (int s = 0; s < 4; s++)
        begin
            bus_wr(8'h74, 8'h90 | 8'(s), 4'hf);
            feed(2 * (8 << s), 8'h21);
            bnd = 8'(4 * (s + 1));
            ook_probe(8'h22 - bnd, 1'b1);
            ook_probe(8'h21 - bnd, 1'b0);
        end
        // large dead zone ignores a small deviation, the smallest does not
        bus_wr(8'h74, 8'hc0, 4'hf);
        feed(64, 8'h25);
        chk_gain("analog_gain", 3'h2, analog_gain);
        bus_wr(8'h74, 8'h00, 4'hf);
        feed(8, 8'h25);
        chk_gain("analog_gain", 3'h3, analog_gain);
        tally_and_finish();
    end

endmodule
`default_nettype wire
